// [oca_consts.vh]
// constants for the option configuration access block
`ifndef OCA_CONSTS_VH
`define OCA_CONSTS_VH

// sfr byte addresses of the two access registers
`define OCA_ADDR_OPTION_INDEX   8'hFE
`define OCA_ADDR_OPTION_DATA    8'hFF

// option register addresses as loaded into option_index
`define OCA_IDX_WORD_ZERO       8'hC1
`define OCA_IDX_WORD_ONE        8'hC2
`define OCA_IDX_OSC_TRIM        8'h83

// reset values
`define OCA_RST_OPTION_INDEX    8'h00
`define OCA_RST_OPTION_WORD     8'h00
`define OCA_RST_OSC_TRIM        8'h80

// option_word_zero field positions
`define OCA_BIT_WATCHDOG_ON     7

// option_word_one field positions
`define OCA_BIT_DEBUG_DISABLE   4
`define OCA_RANGE_HI            3
`define OCA_RANGE_LO            2
`define OCA_BOOT_HI             1
`define OCA_BOOT_LO             0
`define OCA_BOOT_MASK           8'h03

// self-program range encodings
`define OCA_RANGE_NONE          2'b00
`define OCA_RANGE_LAST_1K       2'b01
`define OCA_RANGE_LAST_2K       2'b10
`define OCA_RANGE_ALL           2'b11

// flash geometry
`define OCA_FLASH_TOP           16'hFFFF
`define OCA_SIZE_1K             16'h0400
`define OCA_SIZE_2K             16'h0800
`define OCA_SIZE_4K             16'h1000

`endif

// [oca_flash_guard.v]
// flash access permission checker for self-programming and table reads
`timescale 1ns/1ns
`default_nettype none
`include "oca_consts.vh"

module oca_flash_guard
(
  input  wire [1:0]  boot_area_size_i,
  input  wire [1:0]  self_program_range_i,
  input  wire        exec_from_boot_i,
  input  wire [15:0] iap_addr_i,
  input  wire [15:0] table_addr_i,
  output wire        iap_allowed_o,
  output wire        table_allowed_o
);

  // ***********************************************
  // boot area geometry
  // ***********************************************

  // size in bytes reserved at the top of flash for the boot area
  function [15:0] boot_bytes;
    input [1:0] code;
    begin
      case (code)
        2'b01:   boot_bytes = `OCA_SIZE_1K;
        2'b10:   boot_bytes = `OCA_SIZE_2K;
        2'b11:   boot_bytes = `OCA_SIZE_4K;
        default: boot_bytes = 16'h0000;
      endcase
    end
  endfunction

  // true when an address falls inside the boot area
  function in_boot;
    input [1:0]  code;
    input [15:0] addr;
    begin
      in_boot = (code != 2'b00) &&
                ({1'b0, addr} > ({1'b0, `OCA_FLASH_TOP} - {1'b0, boot_bytes(code)}));
    end
  endfunction

  wire [15:0] app_end;
  wire        iap_in_boot;
  wire        table_in_boot;
  reg         window_ok;

  // application flash ends just below the boot area
  assign app_end = `OCA_FLASH_TOP - boot_bytes(boot_area_size_i);
  assign iap_in_boot   = in_boot(boot_area_size_i, iap_addr_i);
  assign table_in_boot = in_boot(boot_area_size_i, table_addr_i);

  // window of application flash open to self-programming
  always @*
  begin
    case (self_program_range_i)
      `OCA_RANGE_NONE:    window_ok = 1'b0;
      `OCA_RANGE_LAST_1K: window_ok = ({1'b0, iap_addr_i} + {1'b0, `OCA_SIZE_1K}) > {1'b0, app_end};
      `OCA_RANGE_LAST_2K: window_ok = ({1'b0, iap_addr_i} + {1'b0, `OCA_SIZE_2K}) > {1'b0, app_end};
      default:            window_ok = 1'b1;
    endcase
  end

  // boot area never programmable; boot code ignores the window
  assign iap_allowed_o = !iap_in_boot && (exec_from_boot_i || window_ok);

  // boot code may read both areas; application code may not read boot
  assign table_allowed_o = exec_from_boot_i || !table_in_boot;

endmodule
`default_nettype wire

// [oca_option_config.v]
// option configuration access block: index/data registers and option words
// What this block does
// - index register selects option register; data register reads/writes the selected one
// - debug disable bit 0 gives pins to debug; 1 makes them normal I/O
// - range field 00 none, 01 last 1K, 10 last 2K, 11 all application flash
// - running from boot area ignores range, whole application flash programmable
// - self-programming of the boot area is always refused
// - boot code table-reads both areas; application code cannot program boot
// - boot size field read-only; 00 means no boot, application 0000H-FFFFH
// - nonzero boot size reserves top of flash, shrinking application space
// - each trim step moves oscillator frequency about 0.18 percent
// - trim register loaded with factory 32MHz value after every power-on
// - watchdog on runs but pauses during self-programming; off means inactive
`timescale 1ns/1ns
`default_nettype none
`include "oca_consts.vh"

module oca_option_config
(
  input  wire        clk_sys_i,
  input  wire        reset_n_i,
  // special function register bus
  input  wire [7:0]  sfr_addr_i,
  input  wire [7:0]  sfr_wdata_i,
  input  wire        sfr_wr_i,
  input  wire        sfr_rd_i,
  output reg  [7:0]  sfr_rdata_o,
  // factory values presented by the option flash loader
  input  wire [7:0]  option_word_zero_init_i,
  input  wire [7:0]  option_word_one_init_i,
  input  wire [7:0]  oscillator_trim_init_i,
  // flash access requests
  input  wire        exec_from_boot_i,
  input  wire [15:0] iap_addr_i,
  input  wire [15:0] table_addr_i,
  input  wire        iap_busy_i,
  output wire        iap_allowed_o,
  output wire        table_allowed_o,
  // controls to the rest of the chip
  output reg         debug_port_enable_o,
  output reg         watchdog_count_en_o,
  output reg  [7:0]  oscillator_trim_o,
  output reg         options_loaded_o
);

  // ***********************************************
  // registers
  // ***********************************************

  reg  [7:0] option_index;
  reg  [7:0] option_word_zero;
  reg  [7:0] option_word_one;
  reg  [7:0] oscillator_trim;
  reg        load_pending;

  reg  [7:0] next_selected;
  reg  [7:0] next_word_one;

  wire       wr_index;
  wire       wr_data;
  wire       rd_data;
  wire       rd_index;

  // ***********************************************
  // bus decode
  // ***********************************************

  // decode of the two access addresses
  assign wr_index = sfr_wr_i && (sfr_addr_i == `OCA_ADDR_OPTION_INDEX);
  assign wr_data  = sfr_wr_i && (sfr_addr_i == `OCA_ADDR_OPTION_DATA);
  assign rd_index = sfr_rd_i && (sfr_addr_i == `OCA_ADDR_OPTION_INDEX);
  assign rd_data  = sfr_rd_i && (sfr_addr_i == `OCA_ADDR_OPTION_DATA);

  // value of the option register selected by the index
  always @*
  begin
    if (option_index == `OCA_IDX_WORD_ZERO)
    begin
      next_selected = option_word_zero;
    end
    else if (option_index == `OCA_IDX_WORD_ONE)
    begin
      next_selected = option_word_one;
    end
    else if (option_index == `OCA_IDX_OSC_TRIM)
    begin
      next_selected = oscillator_trim;
    end
    else
    begin
      next_selected = 8'h00;  // undefined option address reads zero
    end
  end

  // boot size bits keep their value on a write
  always @*
  begin
    next_word_one = (sfr_wdata_i & ~`OCA_BOOT_MASK) | (option_word_one & `OCA_BOOT_MASK);
  end

  // ***********************************************
  // index register
  // ***********************************************

  // index holds the selected option address
  always @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      option_index <= `OCA_RST_OPTION_INDEX;
    end
    else if (wr_index)
    begin
      option_index <= sfr_wdata_i;
    end
  end

  // ***********************************************
  // option registers
  // ***********************************************

  // factory load in the first cycle after reset, then software writes
  always @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      option_word_zero <= `OCA_RST_OPTION_WORD;
      option_word_one  <= `OCA_RST_OPTION_WORD;
      oscillator_trim  <= `OCA_RST_OSC_TRIM;
      load_pending     <= 1'b1;
    end
    else if (load_pending)
    begin
      option_word_zero <= option_word_zero_init_i;
      option_word_one  <= option_word_one_init_i;
      oscillator_trim  <= oscillator_trim_init_i;
      load_pending     <= 1'b0;
    end
    else if (wr_data)
    begin
      // undefined index: the write is dropped
      if (option_index == `OCA_IDX_WORD_ZERO)
      begin
        option_word_zero <= sfr_wdata_i;
      end
      else if (option_index == `OCA_IDX_WORD_ONE)
      begin
        option_word_one <= next_word_one;
      end
      else if (option_index == `OCA_IDX_OSC_TRIM)
      begin
        oscillator_trim <= sfr_wdata_i;
      end
    end
  end

  // ***********************************************
  // read data
  // ***********************************************

  // read data registered, valid the cycle after the strobe
  always @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      sfr_rdata_o <= 8'h00;
    end
    else if (rd_index)
    begin
      sfr_rdata_o <= option_index;
    end
    else if (rd_data)
    begin
      sfr_rdata_o <= next_selected;
    end
  end

  // ***********************************************
  // control outputs
  // ***********************************************

  // controls driven from the live option words
  always @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      debug_port_enable_o <= 1'b0;
      watchdog_count_en_o <= 1'b0;
      oscillator_trim_o   <= `OCA_RST_OSC_TRIM;
      options_loaded_o    <= 1'b0;
    end
    else
    begin
      debug_port_enable_o <= !option_word_one[`OCA_BIT_DEBUG_DISABLE] && !load_pending;
      watchdog_count_en_o <= option_word_zero[`OCA_BIT_WATCHDOG_ON] && !iap_busy_i
                             && !load_pending;
      oscillator_trim_o   <= oscillator_trim;
      options_loaded_o    <= !load_pending;
    end
  end

  // ***********************************************
  // flash access guard
  // ***********************************************

  oca_flash_guard u_guard
  (
    .boot_area_size_i     (option_word_one[`OCA_BOOT_HI:`OCA_BOOT_LO]),
    .self_program_range_i (option_word_one[`OCA_RANGE_HI:`OCA_RANGE_LO]),
    .exec_from_boot_i     (exec_from_boot_i),
    .iap_addr_i           (iap_addr_i),
    .table_addr_i         (table_addr_i),
    .iap_allowed_o        (iap_allowed_o),
    .table_allowed_o      (table_allowed_o)
  );

endmodule
`default_nettype wire

// [oca_option_config_props.sv]
// port-level assertions for the option configuration block
`timescale 1ns/1ns
`default_nettype none
module oca_props
(
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  input wire logic [7:0]  sfr_addr_i,
  input wire logic [7:0]  sfr_wdata_i,
  input wire logic        sfr_wr_i,
  input wire logic        sfr_rd_i,
  input wire logic [7:0]  sfr_rdata_o,
  input wire logic [7:0]  option_word_one_init_i,
  input wire logic        exec_from_boot_i,
  input wire logic [15:0] iap_addr_i,
  input wire logic [15:0] table_addr_i,
  input wire logic        iap_busy_i,
  input wire logic        iap_allowed_o,
  input wire logic        table_allowed_o,
  input wire logic        debug_port_enable_o,
  input wire logic        watchdog_count_en_o,
  input wire logic [7:0]  oscillator_trim_o,
  input wire logic        options_loaded_o
);
  // ****
  // helpers
  // ****
  default clocking cb @(posedge clk_sys_i); endclocking
  wire [1:0] bsz = option_word_one_init_i[1:0];
  // address lies in the boot area for a given boot size
  function automatic logic f_boot(input logic [15:0] a, input logic [1:0] s);
    f_boot = (s == 2'h1) ? a > 16'hFBFF : (s == 2'h2) ? a > 16'hF7FF : (s == 2'h3) && a > 16'hEFFF;
  endfunction
  sequence s_pick(v);
    sfr_wr_i && sfr_addr_i == 8'hFE && sfr_wdata_i == v;
  endsequence
  sequence s_put;
    sfr_wr_i && sfr_addr_i == 8'hFF;
  endsequence
  // ****
  // properties
  // ****
  property p_load;
    !reset_n_i ##1 reset_n_i [*3] |-> options_loaded_o;
  endproperty
  a_load: assert property (p_load) else $error("options not loaded");
  property p_rdhold;
    disable iff (!reset_n_i) !(sfr_rd_i && sfr_addr_i[7:1] == 7'h7F) |=> $stable(sfr_rdata_o);
  endproperty
  a_rdhold: assert property (p_rdhold) else $error("read data moved");
  property p_dbg;
    disable iff (!reset_n_i) s_pick(8'hC2) ##2 s_put |-> ##2 debug_port_enable_o == !$past(sfr_wdata_i[4], 2);
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug port wrong");
  property p_trim;
    disable iff (!reset_n_i) s_pick(8'h83) ##2 s_put |-> ##2 oscillator_trim_o == $past(sfr_wdata_i, 2);
  endproperty
  a_trim: assert property (p_trim) else $error("trim not written");
  property p_wdog;
    disable iff (!reset_n_i) options_loaded_o && iap_busy_i |=> !watchdog_count_en_o;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog runs in iap");
  property p_noboot;
    disable iff (!reset_n_i) options_loaded_o && f_boot(iap_addr_i, bsz) |-> !iap_allowed_o;
  endproperty
  a_noboot: assert property (p_noboot) else $error("boot area programmable");
  property p_bootexec;
    disable iff (!reset_n_i) options_loaded_o && exec_from_boot_i && !f_boot(iap_addr_i, bsz) |-> iap_allowed_o;
  endproperty
  a_bootexec: assert property (p_bootexec) else $error("boot code refused");
  property p_table;
    disable iff (!reset_n_i) options_loaded_o |-> table_allowed_o == (exec_from_boot_i || !f_boot(table_addr_i, bsz));
  endproperty
  a_table: assert property (p_table) else $error("table read wrong");
endmodule
bind oca_option_config oca_props i_props
(
  .clk_sys_i, .reset_n_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o,
  .option_word_one_init_i, .exec_from_boot_i, .iap_addr_i, .table_addr_i, .iap_busy_i,
  .iap_allowed_o, .table_allowed_o, .debug_port_enable_o, .watchdog_count_en_o,
  .oscillator_trim_o, .options_loaded_o
);
`default_nettype wire

// [testbench.sv]
// self-checking testbench for the option configuration block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk_sys_i = 0;
  logic        reset_n_i = 0;
  logic [7:0]  sfr_addr_i = 0;
  logic [7:0]  sfr_wdata_i = 0;
  logic        sfr_wr_i = 0;
  logic        sfr_rd_i = 0;
  logic [7:0]  w1_init = 8'h03;
  logic        exec_from_boot_i = 0;
  logic [15:0] iap_addr_i = 0;
  logic        iap_busy_i = 0;
  wire  [7:0]  sfr_rdata_o;
  wire  [7:0]  oscillator_trim_o;
  wire         iap_allowed_o;
  wire         table_allowed_o;
  wire         debug_port_enable_o;
  wire         watchdog_count_en_o;
  wire         options_loaded_o;
  int          bad_count = 0;
  int          checks = 0;
  // ****
  // design and clock
  // ****
  oca_option_config i_oca_option_config
  (
    .clk_sys_i, .reset_n_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o,
    .option_word_zero_init_i(8'h00), .option_word_one_init_i(w1_init), .oscillator_trim_init_i(8'h5A),
    .exec_from_boot_i, .iap_addr_i, .table_addr_i(iap_addr_i), .iap_busy_i, .iap_allowed_o,
    .table_allowed_o, .debug_port_enable_o, .watchdog_count_en_o, .oscillator_trim_o, .options_loaded_o
  );
  always #2 clk_sys_i = ~clk_sys_i;
  // ****
  // tasks
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    sfr_wr_i <= 1;
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    @(posedge clk_sys_i);
    sfr_wr_i <= 0;
  endtask
  // read data lands one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    sfr_rd_i <= 1;
    sfr_addr_i <= a;
    @(posedge clk_sys_i);
    sfr_rd_i <= 0;
    #1 check(sfr_rdata_o, e);
  endtask
  task automatic do_reset(input logic [7:0] w1);
    @(posedge clk_sys_i);
    reset_n_i <= 0;
    w1_init <= w1;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1;
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask
  // expected iap and table permission from boot top, range and exec area
  function automatic logic [1:0] f_exp(input logic [15:0] a, input logic [1:0] r, input logic ex,
                                       input logic [15:0] top);
    logic ib;
    logic win;
    ib = a > top;
    win = r == 2'h3 || (r == 2'h1 && a >= top - 16'h03FF) || (r == 2'h2 && a >= top - 16'h07FF);
    f_exp = {!ib && (ex || win), ex || !ib};
  endfunction
  task automatic sweep(input logic [15:0] top);
    logic [15:0] adr [8] = '{16'h0000, 16'hE7FF, 16'hEBFF, 16'hEC00, 16'hF7FF, 16'hFBFF, 16'hFC00, 16'hFFFF};
    for (int n = 0; n < 64; n++)
    begin
      if (n[2:0] == 0)
      begin
        wr(8'hFE, 8'hC2);
        wr(8'hFF, {4'h1, n[4:3], 2'h0});
      end
      @(posedge clk_sys_i);
      exec_from_boot_i <= n[5];
      iap_addr_i <= adr[n[2:0]];
      @(posedge clk_sys_i);
      #1 check({iap_allowed_o, table_allowed_o}, f_exp(adr[n[2:0]], n[4:3], n[5], top));
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial
  begin
    do_reset(8'h03);
    check(options_loaded_o, 1'h1);
    check(oscillator_trim_o, 8'h5A);
    check(debug_port_enable_o, 1'h1);
    rd(8'hFE, 8'h00);
    $display("test reset done");
    wr(8'hFE, 8'hC1);
    rd(8'hFE, 8'hC1);
    rd(8'hFF, 8'h00);
    wr(8'hFF, 8'h80);
    rd(8'hFF, 8'h80);
    check(watchdog_count_en_o, 1'h1);
    @(posedge clk_sys_i);
    iap_busy_i <= 1;
    @(posedge clk_sys_i);
    #1 check(watchdog_count_en_o, 1'h0);
    @(posedge clk_sys_i);
    iap_busy_i <= 0;
    wr(8'hFE, 8'hC2);
    wr(8'hFF, 8'h1C);
    rd(8'hFF, 8'h1F);
    check(debug_port_enable_o, 1'h0);
    wr(8'hFE, 8'h83);
    wr(8'hFF, 8'h5B);
    rd(8'hFF, 8'h5B);
    check(oscillator_trim_o, 8'h5B);
    // undefined index: write dropped, data reads zero
    wr(8'hFE, 8'h40);
    wr(8'hFF, 8'h55);
    rd(8'hFF, 8'h00);
    rd(8'hFE, 8'h40);
    // other addresses leave the read data as it was
    rd(8'h80, 8'h40);
    $display("test registers done");
    sweep(16'hEFFF);
    $display("test guard done");
    do_reset(8'h01);
    sweep(16'hFBFF);
    do_reset(8'h02);
    sweep(16'hF7FF);
    $display("test small boot done");
    do_reset(8'h0C);
    check(oscillator_trim_o, 8'h5A);
    check(debug_port_enable_o, 1'h1);
    check(watchdog_count_en_o, 1'h0);
    sweep(16'hFFFF);
    $display("test no boot done");
    final_report();
  end
  // watchdog against a hang
  initial
  begin
    #20000;
    bad_count++;
    final_report();
  end
endmodule
`default_nettype wire
